// File: dv/strap_board.sv
`timescale 1ns/100ps
module strap_board (
  input  wire psq_pkg::cfg_pins_s i_strap,
  input  wire psq_pkg::cfg_pins_s i_pin_out,
  input  wire psq_pkg::cfg_pins_s i_pin_oe,
  output psq_pkg::cfg_pins_s      o_pin
);
  import psq_pkg::*;

  // Driven pins show the device value, released pins fall back to the strap resistor
  assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_strap);
endmodule : strap_board

// File: dv/test_powerup_strap_and_powerdown.sv
`timescale 1ns/100ps
module test_powerup_strap_and_powerdown;
  import psq_pkg::*;

  logic       clk;
  logic       srst;
  cfg_pins_s  strap;
  cfg_pins_s  pin_in;
  cfg_pins_s  pin_out;
  cfg_pins_s  pin_oe;
  cfg_pins_s  sync;
  pin_src_s   src;
  reg_req_s   req;
  mode_s      mode;
  logic [7:0] pd;
  logic [7:0] rdata;
  logic       done;
  int         error_cnt;
  int         tests_run;
  logic [4:0] cases [5] = '{5'h0b, 5'h0d, 5'h10, 5'h12, 5'h11};

  powerup_strap_and_powerdown uut (
    .I_CLOCK(clk), .I_SRST(srst), .I_PIN_IN(pin_in), .I_PIN_SRC(src), .I_REG(req),
    .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe), .O_PIN_SYNC(sync), .O_MODE(mode),
    .O_POWER_DOWN(pd), .O_REG_RDATA(rdata), .O_CONFIG_DONE(done)
  );

  strap_board board (.i_strap(strap), .i_pin_out(pin_out), .i_pin_oe(pin_oe), .o_pin(pin_in));

  // Free running crystal clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Pin roles expected after the hold
  function automatic logic [4:0] exp_oe(input cfg_pins_s s, input pin_src_s p);
    if (!s.serial_data_in_pin) return 5'h0f;
    if (!s.first_general_output_pin) return {p.serial_out_en & ~p.serial_out_data, 4'h7};
    return {2'b00, p.serial_out_en, 2'b01};
  endfunction : exp_oe

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  // One register write, then read back through the same address
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{1'b1, a, d};
    @(negedge clk);
    req.wr = 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic run_test(input cfg_pins_s s);
    int         n;
    logic [7:0] d;
    @(negedge clk);
    strap = s;
    src = pin_src_s'(9'($urandom));
    srst = 1'b1;
    repeat (6) @(negedge clk);
    chk("reset_pd", POWER_DOWN_CONTROL_RST, pd);
    srst = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
      if (done !== 1'b1) chk("hold_oe", 16'h0, pin_oe);
    end
    chk("hold_len", 16'd256, 16'(n));
    chk("pin_sync", strap, sync);
    @(negedge clk);
    chk("mode_sw", s.serial_data_in_pin, mode.software_control_select);
    chk("pd_start", s.serial_data_in_pin ? 8'h07 : 8'h00, pd);
    chk("pin_oe", exp_oe(s, src), pin_oe);
    if (!s.serial_data_in_pin) begin
      chk("audio_if_master_slave", s.serial_clock_pin, mode.audio_if_master_slave);
      chk("aif_fmt", {s.first_general_output_pin, s.serial_data_out_pin},
          mode.audio_if_format_code);
      chk("tx_src", s.chip_select_pin, mode.transmit_source_select);
      chk("hw_out", {src.transmit_error_flag, src.non_audio_flag, src.unlock_flag,
          src.general_flag_output}, pin_out[3:0]);
      wr(REG_POWER_DOWN_CONTROL_ADDR, 8'h3f);
      chk("hw_pd", 8'h00, pd);
    end else begin
      chk("iface", s.first_general_output_pin, mode.control_interface_select);
      chk("sw_out", s.first_general_output_pin ?
          {2'b00, src.serial_out_data, 1'b0, src.general_output[2]} :
          {2'b00, src.general_output[0], src.general_output[1], src.general_output[2]},
          pin_out);
      if (!s.first_general_output_pin)
        chk("dev_addr", s.chip_select_pin ? 7'h3b : 7'h3a, mode.device_addr);
      for (int k = 0; k < 4; k++) begin
        d = (k == 0) ? 8'hff : (k == 3) ? 8'h00 : 8'($urandom);
        wr(REG_POWER_DOWN_CONTROL_ADDR, d);
        chk("pd_wr", d & 8'h3f, pd);
        chk("pd_rd", d & 8'h3f, rdata);
        chk("oe_z", d[5] ? 5'h00 : exp_oe(s, src), pin_oe);
      end
      wr(7'h1d, 8'h3f);
      chk("pd_other", 8'h00, pd);
      chk("rd_other", 8'h00, rdata);
    end
  endtask : run_test

  // Main sequence: fixed corner straps then random straps
  initial begin
    srst = 1'b1;
    strap = '0;
    src = '0;
    req = '0;
    error_cnt = 0;
    tests_run = 0;
    void'($urandom(32'he6021b3f));
    for (int i = 0; i < 9; i++) begin
      run_test(i < 5 ? cfg_pins_s'(cases[i]) : cfg_pins_s'(5'($urandom)));
      $display("Test %0d done, straps %b", i, strap);
    end
    test_done();
  end

  // Watchdog well beyond nine hold sequences
  initial begin
    repeat (10000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule : test_powerup_strap_and_powerdown

// File: hw/hold_timer.sv
`timescale 1ns/100ps
module hold_timer #(
  parameter int HOLD_CYC = psq_pkg::HOLD_CYC
) (
  input  wire logic i_clock,
  input  wire logic i_srst,
  output logic      o_capture,
  output logic      o_expired
);
  import psq_pkg::*;

  typedef struct packed {
    logic [HOLD_CNT_W-1:0] cnt;
  } tmr_s;

  localparam logic [HOLD_CNT_W-1:0] LAST = HOLD_CNT_W'(HOLD_CYC);
  localparam logic [HOLD_CNT_W-1:0] CAPT = HOLD_CNT_W'(HOLD_CYC - 2);
  localparam logic [HOLD_CNT_W-1:0] ONE  = HOLD_CNT_W'(1);

  tmr_s st_r;
  tmr_s st_nxt;

  // Count crystal cycles from reset release, stop at the end
  always_comb begin
    st_nxt = st_r;
    if (st_r.cnt != LAST) begin
      st_nxt.cnt = st_r.cnt + ONE;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Strap capture lands two cycles before the end
  assign o_capture = (st_r.cnt == CAPT);
  assign o_expired = (st_r.cnt == LAST);

endmodule : hold_timer

// File: hw/powerup_strap_and_powerdown.sv
// Operation
// (R01) The operating mode comes from the five configuration pins sampled after power-up or reset.
// (R02) After reset release every configuration pin stays an input for 9.4us to 25.6us.
// (R03) The hold interval is timed from the crystal clock so it scales with crystal frequency.
// (R04) The hold is a counter of about 256 crystal cycles with straps captured before it expires.
// (R05) After the hold each pin takes its role for software or hardware control mode.
// (R06) A low data-input strap selects hardware control, a high one software control.
// (R07) In software mode a low first-general-output strap selects two-wire, high three-wire.
// (R08) In two-wire mode the chip-select strap picks device address 0111010x or 0111011x.
// (R09) In hardware mode the straps set master/slave, the two-bit format code and tx source.
// (R10) Starting in software mode, functions stay powered down until software clears their bits.
// (R11) Starting in hardware mode, every function is powered up without register access.
// (R12) Power-down bits 0, 1 and 2 switch off PLL, receiver and transmitter and reset to 1.
// (R13) Power-down bits 3 and 4 switch off oscillator and audio interface and reset to 0.
// (R14) Power-down bit 5 puts every pin output in high impedance and resets to 0.
// (R15) A hardware reset restores the power-down default and repeats strap sampling.
`timescale 1ns/100ps
module powerup_strap_and_powerdown (
  input  wire logic               I_CLOCK,
  input  wire logic               I_SRST,
  input  wire psq_pkg::cfg_pins_s I_PIN_IN,
  input  wire psq_pkg::pin_src_s  I_PIN_SRC,
  input  wire psq_pkg::reg_req_s  I_REG,
  output psq_pkg::cfg_pins_s      O_PIN_OUT,
  output psq_pkg::cfg_pins_s      O_PIN_OE,
  output psq_pkg::cfg_pins_s      O_PIN_SYNC,
  output psq_pkg::mode_s          O_MODE,
  output logic [7:0]              O_POWER_DOWN,
  output logic [7:0]              O_REG_RDATA,
  output logic                    O_CONFIG_DONE
);
  import psq_pkg::*;

  typedef struct packed {
    phase_e    phase;
    cfg_pins_s sync1;
    cfg_pins_s sync2;
    mode_s     mode;
    logic [7:0] power_down_control;
    cfg_pins_s pin_out;
    cfg_pins_s pin_oe;
    logic [7:0] rdata;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic   capture;
  logic   expired;

  // Hold interval timer on the crystal clock
  hold_timer #(
    .HOLD_CYC (HOLD_CYC)
  ) u_hold_timer (
    .i_clock   (I_CLOCK),
    .i_srst    (I_SRST),
    .o_capture (capture),
    .o_expired (expired)
  );

  // Next state of the whole block
  always_comb begin
    st_nxt       = st_r;
    st_nxt.sync1 = I_PIN_IN;
    st_nxt.sync2 = st_r.sync1;
    // Strap capture from synchronised pins
    if (st_r.phase == PH_HOLD && capture) begin // R04
      st_nxt.mode.software_control_select  = st_r.sync2.serial_data_in_pin; // R01 R06
      st_nxt.mode.control_interface_select = st_r.sync2.first_general_output_pin; // R07
      st_nxt.mode.device_addr = st_r.sync2.chip_select_pin ? DEV_ADDR_HIGH
                                                           : DEV_ADDR_LOW; // R08
      st_nxt.mode.audio_if_master_slave  = st_r.sync2.serial_clock_pin; // R09
      st_nxt.mode.audio_if_format_code   = {st_r.sync2.first_general_output_pin,
                                            st_r.sync2.serial_data_out_pin}; // R09
      st_nxt.mode.transmit_source_select = st_r.sync2.chip_select_pin; // R09
    end
    // End of hold, release pins and settle power state
    if (st_r.phase == PH_HOLD && expired) begin // R02 R03
      st_nxt.phase = PH_RUN;
      if (!st_r.mode.software_control_select) begin
        st_nxt.power_down_control = POWER_DOWN_CONTROL_HW_VAL; // R11
      end
    end
    // Software writes to the power-down register
    if (st_r.phase == PH_RUN && st_r.mode.software_control_select && I_REG.wr &&
        I_REG.addr == REG_POWER_DOWN_CONTROL_ADDR) begin // R10 R12 R13
      st_nxt.power_down_control = I_REG.wdata & POWER_DOWN_CONTROL_MASK;
    end
    // Read data of the addressed register
    if (I_REG.addr == REG_POWER_DOWN_CONTROL_ADDR) begin
      st_nxt.rdata = st_r.power_down_control;
    end else begin
      st_nxt.rdata = RDATA_NONE;
    end
    // Pin roles after the hold
    st_nxt.pin_out = '0;
    st_nxt.pin_oe  = '0;
    if (st_nxt.phase == PH_RUN) begin // R05
      if (!st_nxt.mode.software_control_select) begin
        st_nxt.pin_out.serial_clock_pin         = I_PIN_SRC.transmit_error_flag;
        st_nxt.pin_out.serial_data_out_pin      = I_PIN_SRC.non_audio_flag;
        st_nxt.pin_out.chip_select_pin          = I_PIN_SRC.unlock_flag;
        st_nxt.pin_out.first_general_output_pin = I_PIN_SRC.general_flag_output;
        st_nxt.pin_oe.serial_clock_pin          = 1'b1;
        st_nxt.pin_oe.serial_data_out_pin       = 1'b1;
        st_nxt.pin_oe.chip_select_pin           = 1'b1;
        st_nxt.pin_oe.first_general_output_pin  = 1'b1;
      end else if (!st_nxt.mode.control_interface_select) begin
        // Two-wire: open-drain acknowledge on the data pin, clock stays an input, the other three are outputs
        st_nxt.pin_out.serial_data_in_pin       = 1'b0;
        st_nxt.pin_oe.serial_data_in_pin        = I_PIN_SRC.serial_out_en &
                                                  ~I_PIN_SRC.serial_out_data;
        st_nxt.pin_out.serial_data_out_pin      = I_PIN_SRC.general_output[0];
        st_nxt.pin_out.chip_select_pin          = I_PIN_SRC.general_output[1];
        st_nxt.pin_out.first_general_output_pin = I_PIN_SRC.general_output[2];
        st_nxt.pin_oe.serial_data_out_pin       = 1'b1;
        st_nxt.pin_oe.chip_select_pin           = 1'b1;
        st_nxt.pin_oe.first_general_output_pin  = 1'b1;
      end else begin
        // Three-wire: read-back data out, chip select stays an input
        st_nxt.pin_out.serial_data_out_pin      = I_PIN_SRC.serial_out_data;
        st_nxt.pin_oe.serial_data_out_pin       = I_PIN_SRC.serial_out_en;
        st_nxt.pin_out.first_general_output_pin = I_PIN_SRC.general_output[2];
        st_nxt.pin_oe.first_general_output_pin  = 1'b1;
      end
    end
    // Global tri-state overrides every enable
    if (st_nxt.power_down_control[BIT_HIGH_Z]) begin // R14
      st_nxt.pin_oe = '0;
    end
  end

  // Register the state; reset repeats the whole sequence
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin // R15
      st_r                              <= '0;
      st_r.phase                        <= PH_HOLD;
      st_r.power_down_control                        <= POWER_DOWN_CONTROL_RST; // R12 R13 R14
      st_r.mode.device_addr             <= DEV_ADDR_LOW;
      st_r.mode.software_control_select <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state flops
  assign O_PIN_OUT     = st_r.pin_out;
  assign O_PIN_OE      = st_r.pin_oe;
  assign O_PIN_SYNC    = st_r.sync2;
  assign O_MODE        = st_r.mode;
  assign O_POWER_DOWN  = st_r.power_down_control;
  assign O_REG_RDATA   = st_r.rdata;
  assign O_CONFIG_DONE = (st_r.phase == PH_RUN);

  // Checking helpers: cycles since reset release
  logic [HOLD_CNT_W:0] since_rst;
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      since_rst <= '0;
    end else if (since_rst != '1) begin
      since_rst <= since_rst + 1'b1;
    end
  end

  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_SRST);

  sequence s_capture;
    (st_r.phase == PH_HOLD) && capture;
  endsequence

  sequence s_release;
    $rose(st_r.phase == PH_RUN);
  endsequence

  sequence s_power_down_control_write;
    (st_r.phase == PH_RUN) && st_r.mode.software_control_select && I_REG.wr &&
    (I_REG.addr == REG_POWER_DOWN_CONTROL_ADDR);
  endsequence

  sequence s_hw_run;
    O_CONFIG_DONE && !O_MODE.software_control_select;
  endsequence

  sequence s_sw_run;
    O_CONFIG_DONE && O_MODE.software_control_select && !O_POWER_DOWN[BIT_HIGH_Z];
  endsequence

  // Hold timing and strap capture
  a_hold_no_drive: assert property ((st_r.phase == PH_HOLD) |-> (O_PIN_OE == '0)) // R02
    else $error("pin driven during hold");

  a_hold_min_time: assert property ((O_PIN_OE != '0) |-> (since_rst >= HOLD_MIN_CYC)) // R02
    else $error("pin driven before minimum hold");

  a_hold_max_time: assert property ((since_rst == HOLD_MAX_CYC) |-> O_CONFIG_DONE) // R03
    else $error("hold exceeded maximum length");

  a_mode_pick: assert property (s_capture |=> // R01
    (O_MODE.software_control_select == $past(st_r.sync2.serial_data_in_pin)))
    else $error("control mode not taken from data strap");

  a_iface_pick: assert property (s_capture |=> // R07
    (O_MODE.control_interface_select == $past(st_r.sync2.first_general_output_pin)))
    else $error("interface type not taken from strap");

  a_dev_addr: assert property (s_capture |=> // R08
    (O_MODE.device_addr == ($past(st_r.sync2.chip_select_pin) ? DEV_ADDR_HIGH : DEV_ADDR_LOW)))
    else $error("device address wrong");

  a_hw_aif_straps: assert property (s_capture |=> // R09
    (O_MODE.audio_if_format_code == $past({st_r.sync2.first_general_output_pin,
                                           st_r.sync2.serial_data_out_pin})) &&
    (O_MODE.transmit_source_select == $past(st_r.sync2.chip_select_pin)))
    else $error("audio interface straps wrong");

  a_capture_first: assert property (s_capture |-> ##[1:4] s_release) // R04
    else $error("hold ended too long after capture");

  a_hw_powerup: assert property (s_release ##0 !O_MODE.software_control_select // R11
    |-> (O_POWER_DOWN == POWER_DOWN_CONTROL_HW_VAL))
    else $error("hardware mode not powered up");

  a_sw_default: assert property (s_release ##0 O_MODE.software_control_select // R10
    |-> (O_POWER_DOWN == POWER_DOWN_CONTROL_RST))
    else $error("software mode not powered down");

  a_power_down_control_write: assert property (s_power_down_control_write |=> // R12
    (O_POWER_DOWN == ($past(I_REG.wdata) & POWER_DOWN_CONTROL_MASK)))
    else $error("power-down write not stored");

  a_tristate_all: assert property (O_POWER_DOWN[BIT_HIGH_Z] |-> (O_PIN_OE == '0)) // R14
    else $error("pin driven while tri-stated");

  a_hw_roles: assert property ((O_CONFIG_DONE && !O_MODE.software_control_select && // R05
    !O_POWER_DOWN[BIT_HIGH_Z]) |-> (O_PIN_OE == 5'h0f))
    else $error("hardware pin roles wrong");

  // Reset return and sticky configuration
  a_reset_defaults: assert property (disable iff (1'b0) I_SRST |=> // R15
    (O_POWER_DOWN == POWER_DOWN_CONTROL_RST) && !O_CONFIG_DONE && (O_PIN_OE == '0))
    else $error("reset defaults not restored");

  a_done_sticky: assert property (O_CONFIG_DONE |=> O_CONFIG_DONE) // R05
    else $error("configuration done dropped");

  a_mode_stable: assert property (O_CONFIG_DONE |=> $stable(O_MODE)) // R01
    else $error("mode changed after the hold");

  a_ms_pick: assert property (s_capture |=> // R09
    (O_MODE.audio_if_master_slave == $past(st_r.sync2.serial_clock_pin)))
    else $error("master/slave not taken from strap");

  a_release_time: assert property (s_release |-> (since_rst == HOLD_MAX_CYC)) // R04
    else $error("hold length not the counted span");

  a_capture_before: assert property (s_capture |-> (since_rst < HOLD_MAX_CYC)) // R04
    else $error("strap capture after the hold end");

  a_sync_delay: assert property (O_CONFIG_DONE |-> (O_PIN_SYNC == $past(I_PIN_IN, 2))) // R01
    else $error("pin synchroniser delay wrong");

  // Power-down register behaviour
  a_hw_pd_locked: assert property (s_hw_run |=> (O_POWER_DOWN == POWER_DOWN_CONTROL_HW_VAL)) // R11
    else $error("hardware mode power state changed");

  a_power_down_control_keep: assert property (O_CONFIG_DONE && !I_REG.wr |=> // R10
    $stable(O_POWER_DOWN))
    else $error("power-down changed without a write");

  a_hold_pd_reset: assert property ((st_r.phase == PH_HOLD) && !expired |=> // R10
    (O_POWER_DOWN == POWER_DOWN_CONTROL_RST))
    else $error("power-down changed during hold");

  a_reserved_zero: assert property ((O_POWER_DOWN & ~POWER_DOWN_CONTROL_MASK) == 8'h00) // R12
    else $error("reserved power-down bits set");

  a_rdata_match: assert property ((I_REG.addr == REG_POWER_DOWN_CONTROL_ADDR) |=> // R12
    (O_REG_RDATA == $past(O_POWER_DOWN)))
    else $error("read data does not follow power-down");

  a_rdata_other: assert property ((I_REG.addr != REG_POWER_DOWN_CONTROL_ADDR) |=> // R12
    (O_REG_RDATA == RDATA_NONE))
    else $error("unmapped read not zero");

  // Pin roles per control mode
  a_two_wire_roles: assert property (s_sw_run ##0 !O_MODE.control_interface_select |-> // R05
    !O_PIN_OE.serial_clock_pin && O_PIN_OE.serial_data_out_pin &&
    O_PIN_OE.chip_select_pin && O_PIN_OE.first_general_output_pin)
    else $error("two-wire pin roles wrong");

  a_three_wire_roles: assert property (s_sw_run ##0 O_MODE.control_interface_select |-> // R05
    !O_PIN_OE.serial_data_in_pin && !O_PIN_OE.serial_clock_pin &&
    !O_PIN_OE.chip_select_pin && O_PIN_OE.first_general_output_pin)
    else $error("three-wire pin roles wrong");

  a_hw_out_flags: assert property (s_hw_run |=> // R05
    (O_PIN_OUT.serial_clock_pin == $past(I_PIN_SRC.transmit_error_flag)) &&
    (O_PIN_OUT.serial_data_out_pin == $past(I_PIN_SRC.non_audio_flag)) &&
    (O_PIN_OUT.chip_select_pin == $past(I_PIN_SRC.unlock_flag)) &&
    (O_PIN_OUT.first_general_output_pin == $past(I_PIN_SRC.general_flag_output)))
    else $error("hardware flag outputs wrong");

endmodule : powerup_strap_and_powerdown

// File: hw/psq_pkg.sv
package psq_pkg;

  // Crystal clock and hold interval timing
  localparam real CLK_MHZ       = 10.0;
  localparam real XTAL_FAST_MHZ = 27.0;
  localparam real XTAL_SLOW_MHZ = 10.0;
  localparam real HOLD_MIN_US   = 9.4;
  localparam real HOLD_MAX_US   = 25.6;
  localparam int  HOLD_MIN_CYC  = int'($ceil(HOLD_MIN_US * CLK_MHZ));
  localparam int  HOLD_MAX_CYC  = int'($floor(HOLD_MAX_US * CLK_MHZ));
  // Last hold cycle; first drive lands one edge later
  localparam int  HOLD_CYC      = HOLD_MAX_CYC - 1;
  localparam int  HOLD_CNT_W    = 10;

  // Register map
  localparam logic [6:0] REG_POWER_DOWN_CONTROL_ADDR = 7'h1e;
  localparam logic [7:0] POWER_DOWN_CONTROL_RST      = 8'h07;
  localparam logic [7:0] POWER_DOWN_CONTROL_HW_VAL   = 8'h00;
  localparam logic [7:0] POWER_DOWN_CONTROL_MASK     = 8'h3f;
  localparam logic [7:0] RDATA_NONE     = 8'h00;
  localparam int         BIT_PLL_OFF    = 0;
  localparam int         BIT_RX_OFF     = 1;
  localparam int         BIT_TX_OFF     = 2;
  localparam int         BIT_OSC_OFF    = 3;
  localparam int         BIT_AIF_OFF    = 4;
  localparam int         BIT_HIGH_Z     = 5;

  // Two-wire device addresses (7-bit, without R/W)
  localparam logic [6:0] DEV_ADDR_LOW   = 7'h3a;
  localparam logic [6:0] DEV_ADDR_HIGH  = 7'h3b;

  typedef enum logic [0:0] {
    PH_HOLD = 1'b0,
    PH_RUN  = 1'b1
  } phase_e;

  // The five configuration pins
  typedef struct packed {
    logic serial_data_in_pin;
    logic serial_clock_pin;
    logic serial_data_out_pin;
    logic chip_select_pin;
    logic first_general_output_pin;
  } cfg_pins_s;

  // Flag and serial sources routed to the pins after the hold
  typedef struct packed {
    logic       transmit_error_flag;
    logic       non_audio_flag;
    logic       unlock_flag;
    logic       general_flag_output;
    logic [2:0] general_output;
    logic       serial_out_data;
    logic       serial_out_en;
  } pin_src_s;

  // Register write/read request from the control interface decoder
  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // Configuration decided from the straps
  typedef struct packed {
    logic       software_control_select;
    logic       control_interface_select;
    logic [6:0] device_addr;
    logic       audio_if_master_slave;
    logic [1:0] audio_if_format_code;
    logic       transmit_source_select;
  } mode_s;

endpackage : psq_pkg
